// ### common/crap_defines.vh
// Purpose: constants for the cpu register access port
// Assumes: plain Verilog-2005, included by bare name
// Notes:   timing counts are in host-port clock cycles
`ifndef CRAP_DEFINES_VH
`define CRAP_DEFINES_VH

// -----------------------------------------------------------------------------
// transfer acknowledge timing
// -----------------------------------------------------------------------------
`define CRAP_SYNC_WR_ACK_CYC   3'd4
`define CRAP_SYNC_RD_ACK_CYC   3'd5
`define CRAP_ASYNC_WR_ACK_LEN  3'd2
`define CRAP_ASYNC_RD_ACK_LEN  3'd3

// -----------------------------------------------------------------------------
// bus widths and parity
// -----------------------------------------------------------------------------
`define CRAP_ADDR_W            20
`define CRAP_DATA_W            16
`define CRAP_PAR_HI_BIT        1
`define CRAP_PAR_LO_BIT        0
`define CRAP_ODD_PARITY        1'b1
`define CRAP_RESET_DATA        16'h0000

`endif

// ### src/crap_reg_mem.v
// Purpose: register storage behind the host port, registered read data
// Assumes: one write or one read per cycle, single clock
// Notes:   storage is little endian: low byte at lower byte address
`timescale 1ns/1ps
`include "crap_defines.vh"

module crap_reg_mem #(
    parameter AW = 8
)(
    input  wire                    clk,
    input  wire                    arst_n,
    input  wire                    wr_en,
    input  wire [AW-1:0]           addr,
    input  wire [15:0]             wr_data,
    output reg  [15:0]             rd_data_ff
);

    reg [7:0] mem_lo [0:(1<<AW)-1];
    reg [7:0] mem_hi [0:(1<<AW)-1];
    integer   i;

    // ---------------------------------------------------------------------
    // storage; reset returns every word to its default value
    // ---------------------------------------------------------------------
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (i = 0; i < (1<<AW); i = i + 1)
            begin
                mem_lo[i] <= 8'h00; // [RULE16]
                mem_hi[i] <= 8'h00;
            end
            rd_data_ff <= `CRAP_RESET_DATA;
        end
        else
        begin
            if (wr_en)
            begin
                mem_lo[addr] <= wr_data[7:0];  // [RULE8]
                mem_hi[addr] <= wr_data[15:8]; // [RULE8]
            end
            rd_data_ff <= {mem_hi[addr], mem_lo[addr]};
        end
    end

endmodule

// ### src/crap_host_port.v
// Purpose: cpu register access port of a framer device
// Assumes: clk is the host port clock; host pins come from outside
// Notes:   open-drain pins are given as an enable alone, high pulling the pin low
//
// Function
// [RULE1] host supplies a 16 to 60 MHz port clock sampling all inputs
// [RULE2] sync select high means synchronous cycles, low asynchronous cycles
// [RULE3] chip select stable before address strobe (sync) or data strobe (async)
// [RULE4] sync address strobe is one clock wide; async held whole cycle
// [RULE5] address latched transparently while address strobe low
// [RULE6] read_not_write high reads, low writes
// [RULE7] data strobe unused in sync; async writes strobe after stable data
// [RULE8] storage little endian, low byte at lowest address
// [RULE9] data bus input on writes, driven by device on reads
// [RULE10] upper parity covers data 15:8, lower parity covers 7:0
// [RULE11] sync acknowledge low at cycle four for writes, five for reads
// [RULE12] async acknowledge low two cycles for writes, three for reads
// [RULE13] acknowledge released on rising edge of address strobe; code drops ack after its count, the rise only exits ST_HOLD
// [RULE14] general interrupt is active-low open drain
// [RULE15] separate active-low open-drain protection switching interrupt
// [RULE16] global reset returns every register to default
// [RULE17] monitor reset pin is input clear or output internal-reset flag
// [RULE18] output enable low tri-states every output
// [RULE19] chip select high: strobes ignored, bus and acknowledge undriven
// [RULE20] byte parity is odd by default, selectable
`timescale 1ns/1ps
`include "crap_defines.vh"

module crap_host_port #(
    parameter MEM_AW     = 8,
    parameter ODD_PARITY = `CRAP_ODD_PARITY
)(
    input  wire                    clk,
    input  wire                    arst_n,
    input  wire                    host_port_sync_select,
    input  wire                    chip_select_n,
    input  wire                    address_strobe_n,
    input  wire                    data_strobe_n,
    input  wire                    read_not_write,
    input  wire [19:0]             addr_in,
    input  wire [15:0]             data_in,
    input  wire [1:0]              byte_parity_in,
    input  wire                    global_output_enable,
    input  wire                    irq_event,
    input  wire                    aps_event,
    input  wire                    pm_reset_is_output,
    input  wire                    pm_internal_reset,
    input  wire                    perf_counter_reset_in,
    output reg  [15:0]             data_out_ff,
    output reg                     data_oe_ff,
    output reg  [1:0]              byte_parity_out_ff,
    output reg                     byte_parity_oe_ff,
    output reg                     transfer_ack_n_oe_ff,
    output reg                     irq_request_n_oe_ff,
    output reg                     protection_switch_irq_n_oe_ff,
    output reg                     perf_counter_reset_out_ff,
    output reg                     perf_counter_reset_oe_ff,
    output reg                     pm_counter_clear_ff,
    output reg                     parity_error_ff
);

    // ---------------------------------------------------------------------
    // state codes, one-hot
    // ---------------------------------------------------------------------
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_WAIT = 4'b0010;
    localparam [3:0] ST_ACK  = 4'b0100;
    localparam [3:0] ST_HOLD = 4'b1000;

    // ---------------------------------------------------------------------
    // input synchronisers: pins come from outside, two flops each
    // ---------------------------------------------------------------------
    reg  [6:0]  sync1_ff;
    reg  [6:0]  sync2_ff;
    reg  [19:0] addr_s1_ff;
    reg  [19:0] addr_s2_ff;
    reg  [15:0] data_s1_ff;
    reg  [15:0] data_s2_ff;
    reg  [1:0]  par_s1_ff;
    reg  [1:0]  par_s2_ff;
    wire [6:0]  raw_in = {perf_counter_reset_in, global_output_enable, host_port_sync_select,
                          chip_select_n, address_strobe_n, data_strobe_n, read_not_write};

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            sync1_ff   <= 7'h3e;
            sync2_ff   <= 7'h3e;
            addr_s1_ff <= 20'h00000;
            addr_s2_ff <= 20'h00000;
            data_s1_ff <= 16'h0000;
            data_s2_ff <= 16'h0000;
            par_s1_ff  <= 2'h0;
            par_s2_ff  <= 2'h0;
        end
        else
        begin
            sync1_ff   <= raw_in;
            sync2_ff   <= sync1_ff;
            addr_s1_ff <= addr_in;
            addr_s2_ff <= addr_s1_ff;
            data_s1_ff <= data_in;
            data_s2_ff <= data_s1_ff;
            par_s1_ff  <= byte_parity_in;
            par_s2_ff  <= par_s1_ff;
        end
    end

    wire pm_in_s  = sync2_ff[6];
    wire oe_s     = sync2_ff[5];
    wire mode_s   = sync2_ff[4];
    wire cs_n_s   = sync2_ff[3];
    wire as_n_s   = sync2_ff[2];
    wire ds_n_s   = sync2_ff[1];
    wire rnw_s    = sync2_ff[0];

    // ---------------------------------------------------------------------
    // cycle control
    // ---------------------------------------------------------------------
    reg  [3:0]  state_ff;
    reg  [3:0]  nxt_state;
    reg  [2:0]  cnt_ff;
    reg  [2:0]  nxt_cnt;
    reg         rnw_ff;
    reg         mode_ff;
    reg         as_prev_ff;
    reg  [19:0] addr_ff;
    reg         wr_en;
    reg         ack_drive;
    wire [15:0] rd_data;

    // sync strobe qualified by chip select alone; async needs both strobes
    wire sync_start  = mode_s & ~cs_n_s & ~as_n_s;                    // [RULE2] [RULE3] [RULE4]
    wire async_start = ~mode_s & ~cs_n_s & ~as_n_s & ~ds_n_s;         // [RULE7] [RULE19]
    wire as_rise     = ~as_prev_ff & as_n_s;                          // [RULE13]
    wire [2:0] sync_target  = rnw_ff ? `CRAP_SYNC_RD_ACK_CYC : `CRAP_SYNC_WR_ACK_CYC;
    wire [2:0] async_length = rnw_ff ? `CRAP_ASYNC_RD_ACK_LEN : `CRAP_ASYNC_WR_ACK_LEN;

    // next-state logic; the write lands on the last ack cycle when data is surely settled
    always @*
    begin
        nxt_state = state_ff;
        nxt_cnt   = cnt_ff;
        wr_en     = 1'b0;
        ack_drive = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                nxt_cnt = 3'd1;
                if (sync_start || async_start)
                    nxt_state = ST_WAIT;
            end
            ST_WAIT:
            begin
                nxt_cnt = cnt_ff + 3'd1;
                if (!mode_ff || (cnt_ff + 3'd1 == sync_target))               // [RULE11]
                begin
                    nxt_state = ST_ACK;
                    nxt_cnt   = 3'd1;
                end
            end
            ST_ACK:
            begin
                ack_drive = 1'b1;
                nxt_cnt   = cnt_ff + 3'd1;
                if (mode_ff || cnt_ff == async_length)                        // [RULE12]
                begin
                    wr_en     = ~rnw_ff;                                      // [RULE6]
                    nxt_state = mode_ff ? ST_IDLE : ST_HOLD;
                end
            end
            ST_HOLD:
            begin
                if (as_rise || cs_n_s)                                        // [RULE13]
                    nxt_state = ST_IDLE;
            end
            default:
                nxt_state = ST_IDLE;
        endcase
    end

    // ---------------------------------------------------------------------
    // state registers; address follows the strobe while it is low
    // ---------------------------------------------------------------------
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_ff   <= ST_IDLE;
            cnt_ff     <= 3'd0;
            rnw_ff     <= 1'b1;
            mode_ff    <= 1'b1;
            as_prev_ff <= 1'b1;
            addr_ff    <= 20'h00000;
        end
        else
        begin
            state_ff   <= nxt_state;
            cnt_ff     <= nxt_cnt;
            as_prev_ff <= as_n_s;
            if (!as_n_s && !cs_n_s)
                addr_ff <= addr_s2_ff;                                        // [RULE5]
            if (state_ff == ST_IDLE)
            begin
                rnw_ff  <= rnw_s;                                             // [RULE6]
                mode_ff <= mode_s;
            end
        end
    end

    crap_reg_mem #(
        .AW         (MEM_AW)
    ) u_mem (
        .clk        (clk),
        .arst_n     (arst_n),
        .wr_en      (wr_en),
        .addr       (addr_ff[MEM_AW-1:0]),
        .wr_data    (data_s2_ff),
        .rd_data_ff (rd_data)
    );

    // ---------------------------------------------------------------------
    // pin drivers; output enable low overrides every driver
    // ---------------------------------------------------------------------
    wire       par_pol = (ODD_PARITY != 0);
    wire       rd_drv  = oe_s & ~cs_n_s & rnw_ff & (state_ff == ST_ACK);      // [RULE9] [RULE18] [RULE19]
    wire [1:0] exp_par = {^data_s2_ff[15:8] ^ par_pol, ^data_s2_ff[7:0] ^ par_pol};

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            data_out_ff                   <= 16'h0000;
            data_oe_ff                    <= 1'b0;
            byte_parity_out_ff            <= 2'h0;
            byte_parity_oe_ff             <= 1'b0;
            transfer_ack_n_oe_ff          <= 1'b0;
            irq_request_n_oe_ff           <= 1'b0;
            protection_switch_irq_n_oe_ff <= 1'b0;
            perf_counter_reset_out_ff     <= 1'b0;
            perf_counter_reset_oe_ff      <= 1'b0;
            pm_counter_clear_ff           <= 1'b0;
            parity_error_ff               <= 1'b0;
        end
        else
        begin
            data_out_ff          <= rd_data;                                          // [RULE9]
            data_oe_ff           <= rd_drv;                                           // [RULE9]
            byte_parity_out_ff[`CRAP_PAR_HI_BIT] <= ^rd_data[15:8] ^ par_pol;         // [RULE10] [RULE20]
            byte_parity_out_ff[`CRAP_PAR_LO_BIT] <= ^rd_data[7:0] ^ par_pol;          // [RULE10] [RULE20]
            byte_parity_oe_ff    <= rd_drv;
            transfer_ack_n_oe_ff <= ack_drive & ~cs_n_s & oe_s;                       // [RULE11] [RULE19]
            irq_request_n_oe_ff  <= irq_event & oe_s;                                 // [RULE14]
            protection_switch_irq_n_oe_ff <= aps_event & oe_s;                        // [RULE15]
            perf_counter_reset_out_ff <= pm_internal_reset;                           // [RULE17]
            perf_counter_reset_oe_ff  <= pm_reset_is_output & oe_s;                   // [RULE17] [RULE18]
            pm_counter_clear_ff  <= pm_reset_is_output ? pm_internal_reset : pm_in_s; // [RULE17]
            // sticky until next write; flags a write whose byte parity mismatched
            if (wr_en)
                parity_error_ff  <= (par_s2_ff != exp_par);                           // [RULE10] [RULE20]
        end
    end

endmodule

// ### dv/crap_host_port_properties.sv
// Purpose: pin-level checks of the cpu register access port
// Assumes: sees only ports of crap_host_port
// Notes:   byte parity is odd unless ODD_PARITY is 0
`timescale 1ns/1ps
module crap_host_port_properties #(
    parameter ODD_PARITY = 1
)(
    input wire logic        clk,
    input wire logic        arst_n,
    input wire logic        host_port_sync_select,
    input wire logic        chip_select_n,
    input wire logic        read_not_write,
    input wire logic        global_output_enable,
    input wire logic        irq_event,
    input wire logic        aps_event,
    input wire logic        pm_reset_is_output,
    input wire logic [15:0] data_out_ff,
    input wire logic        data_oe_ff,
    input wire logic [1:0]  byte_parity_out_ff,
    input wire logic        byte_parity_oe_ff,
    input wire logic        transfer_ack_n_oe_ff,
    input wire logic        irq_request_n_oe_ff,
    input wire logic        protection_switch_irq_n_oe_ff,
    input wire logic        perf_counter_reset_oe_ff
);
// ----------------------------------------
// acknowledge, bus drive, irq and monitor reset lines
// ----------------------------------------
default clocking dc @(posedge clk); endclocking
default disable iff (!arst_n);
property p_cs_idle; chip_select_n [*4] |-> !transfer_ack_n_oe_ff && !data_oe_ff && !byte_parity_oe_ff; endproperty
a_cs_idle: assert property (p_cs_idle) else $error("drive without chip select");
property p_oe_off; !global_output_enable [*4] |-> !(data_oe_ff | transfer_ack_n_oe_ff | byte_parity_oe_ff |
    irq_request_n_oe_ff | protection_switch_irq_n_oe_ff | perf_counter_reset_oe_ff); endproperty
a_oe_off: assert property (p_oe_off) else $error("drive while outputs disabled");
property p_rd_drive; data_oe_ff |-> transfer_ack_n_oe_ff && read_not_write; endproperty
a_rd_drive: assert property (p_rd_drive) else $error("data driven outside read ack");
property p_rd_ack; transfer_ack_n_oe_ff && read_not_write |-> data_oe_ff && byte_parity_oe_ff; endproperty
a_rd_ack: assert property (p_rd_ack) else $error("read ack without data drive");
property p_par; data_oe_ff |-> byte_parity_out_ff ==
    ({~^data_out_ff[15:8], ~^data_out_ff[7:0]} ^ {2{ODD_PARITY == 0}}); endproperty
a_par: assert property (p_par) else $error("read parity wrong");
property p_sync_one; host_port_sync_select && $rose(transfer_ack_n_oe_ff) |=> !transfer_ack_n_oe_ff; endproperty
a_sync_one: assert property (p_sync_one) else $error("sync ack not one cycle");
property p_async_wr; !host_port_sync_select && !read_not_write && $rose(transfer_ack_n_oe_ff)
    |-> transfer_ack_n_oe_ff [*2] ##1 !transfer_ack_n_oe_ff; endproperty
a_async_wr: assert property (p_async_wr) else $error("async write ack length");
property p_async_rd; !host_port_sync_select && read_not_write && $rose(transfer_ack_n_oe_ff)
    |-> transfer_ack_n_oe_ff [*3] ##1 !transfer_ack_n_oe_ff; endproperty
a_async_rd: assert property (p_async_rd) else $error("async read ack length");
property p_irq; global_output_enable [*3] |=> irq_request_n_oe_ff == $past(irq_event)
    && protection_switch_irq_n_oe_ff == $past(aps_event); endproperty
a_irq: assert property (p_irq) else $error("irq line not following event");
property p_pm_in; !pm_reset_is_output [*2] |-> !perf_counter_reset_oe_ff; endproperty
a_pm_in: assert property (p_pm_in) else $error("monitor pin driven as input");
endmodule

// ### dv/crap_host_model.sv
// Purpose: behavioural cpu on the host port pins
// Assumes: pins change 1 ns after clk; ack sampled 1 ns after clk
// Notes:   released address and data show inverted values
`timescale 1ns/1ps
module crap_host_model (
    input  wire logic        clk,
    input  wire logic        host_port_sync_select,
    input  wire logic        transfer_ack_n_oe_ff,
    input  wire logic [15:0] data_out_ff,
    input  wire logic [1:0]  byte_parity_out_ff,
    output logic             chip_select_n,
    output logic             address_strobe_n,
    output logic             data_strobe_n,
    output logic             read_not_write,
    output logic [19:0]      addr_in,
    output logic [15:0]      data_in,
    output logic [1:0]       byte_parity_in
);
// ----------------------------------------
// idle pins and one host cycle
// ----------------------------------------
// cs idles high as its pull-up would hold it
initial
begin
    {chip_select_n, address_strobe_n, data_strobe_n, read_not_write} = 4'hf;
    {addr_in, data_in, byte_parity_in} = '0;
end
// lat of 30 means no acknowledge came
task automatic xfer(input logic sel, rw, bp, input logic [19:0] a, input logic [15:0] d,
                    output logic [15:0] q, output logic [1:0] qp, output int lat, wid);
    lat = 0;
    wid = 0;
    q = 16'h0000;
    qp = 2'h0;
    @(posedge clk);
    #1;
    addr_in = a;
    data_in = d;
    read_not_write = rw;
    chip_select_n = !sel;
    byte_parity_in = {~^d[15:8], ~^d[7:0]} ^ {1'b0, bp};
    @(posedge clk);
    #1;
    address_strobe_n = 1'b0;
    data_strobe_n = host_port_sync_select;
    if (host_port_sync_select)
    begin
        @(posedge clk);
        #1 address_strobe_n = 1'b1;
    end
    // look 1 ns after each edge so the answer has settled
    while (transfer_ack_n_oe_ff !== 1'b1 && lat < 30)
    begin
        @(posedge clk);
        #1;
        lat++;
    end
    q = data_out_ff;
    qp = byte_parity_out_ff;
    while (transfer_ack_n_oe_ff === 1'b1 && wid < 30)
    begin
        @(posedge clk);
        #1;
        wid++;
    end
    {chip_select_n, address_strobe_n, data_strobe_n} = 3'h7;
    addr_in = ~addr_in;
    data_in = ~data_in;
endtask
endmodule

// ### dv/test_crap_host_port.sv
// Purpose: self-checking bench of the cpu register access port
// Assumes: odd parity, MEM_AW of 8
// Notes:   inputs change 1 ns after clk
`timescale 1ns/1ps
module test_crap_host_port;
logic clk, arst_n, host_port_sync_select, chip_select_n, address_strobe_n, data_strobe_n, read_not_write;
logic global_output_enable, irq_event, aps_event, pm_reset_is_output, pm_internal_reset, perf_counter_reset_in;
logic data_oe_ff, byte_parity_oe_ff, transfer_ack_n_oe_ff, irq_request_n_oe_ff, protection_switch_irq_n_oe_ff;
logic perf_counter_reset_out_ff, perf_counter_reset_oe_ff, pm_counter_clear_ff, parity_error_ff;
logic [19:0] addr_in;
logic [15:0] data_in, data_out_ff, q;
logic [1:0]  byte_parity_in, byte_parity_out_ff, qp;
int          errors, samples_checked, lt, w, lw;
crap_host_port u_crap_host_port (.clk, .arst_n, .host_port_sync_select, .chip_select_n, .address_strobe_n,
    .data_strobe_n, .read_not_write, .addr_in, .data_in, .byte_parity_in, .global_output_enable, .irq_event,
    .aps_event, .pm_reset_is_output, .pm_internal_reset, .perf_counter_reset_in, .data_out_ff, .data_oe_ff,
    .byte_parity_out_ff, .byte_parity_oe_ff, .transfer_ack_n_oe_ff, .irq_request_n_oe_ff,
    .protection_switch_irq_n_oe_ff, .perf_counter_reset_out_ff, .perf_counter_reset_oe_ff,
    .pm_counter_clear_ff, .parity_error_ff);
crap_host_model u_crap_host_model (.clk, .host_port_sync_select, .transfer_ack_n_oe_ff, .data_out_ff,
    .byte_parity_out_ff, .chip_select_n, .address_strobe_n, .data_strobe_n, .read_not_write, .addr_in,
    .data_in, .byte_parity_in);
// ----------------------------------------
// helpers
// ----------------------------------------
initial
begin
    clk = 1'b0;
    forever #5 clk = ~clk;
end
task automatic chk(input string nm, input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp)
    begin
        errors++;
        $display("Error %s expected %h seen %h", nm, exp, seen);
    end
endtask
task automatic go(input logic sel, rw, bp, input logic [19:0] a, input logic [15:0] d);
    u_crap_host_model.xfer(sel, rw, bp, a, d, q, qp, lt, w);
endtask
task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
        $display("[ PASS ]");
    else
        $display("[ FAIL ]");
    $finish;
endtask
// ----------------------------------------
// scenarios
// ----------------------------------------
task automatic t_sync;
    go(1, 1, 0, 20'h00005, 16'h0000);
    chk("reset word", q, 0);
    go(1, 0, 0, 20'h000ff, 16'ha5c3);
    lw = lt;
    chk("wr ack width", w, 1);
    go(1, 0, 0, 20'h000fe, 16'h0180);
    go(1, 1, 0, 20'h000ff, 16'h0000);
    chk("rd data", q, 16'ha5c3);
    chk("rd parity", qp, 2'b11);
    chk("rd wait", lt, lw + 1);
    go(1, 1, 0, 20'h000fe, 16'h0000);
    chk("rd data 2", {qp, q}, 18'h00180);
    $display("t_sync done");
endtask
task automatic t_async;
    @(posedge clk);
    #1 host_port_sync_select = 1'b0;
    repeat (4) @(posedge clk);
    go(1, 0, 0, 20'h00010, 16'h7e01);
    chk("async wr width", w, 2);
    go(1, 1, 0, 20'h00010, 16'h0000);
    chk("async rd width", w, 3);
    chk("async rd data", {qp, q}, 18'h27e01);
    @(posedge clk);
    #1 host_port_sync_select = 1'b1;
    repeat (4) @(posedge clk);
    $display("t_async done");
endtask
task automatic t_guard;
    go(1, 0, 1, 20'h00020, 16'h00f0);
    repeat (3) @(posedge clk);
    chk("parity err", parity_error_ff, 1);
    go(1, 0, 0, 20'h00020, 16'h00f0);
    repeat (3) @(posedge clk);
    chk("parity ok", parity_error_ff, 0);
    go(0, 0, 0, 20'h000ff, 16'h1111);
    chk("no select ack", lt, 30);
    go(1, 1, 0, 20'h000ff, 16'h0000);
    chk("unselected kept", q, 16'ha5c3);
    $display("t_guard done");
endtask
task automatic t_pins;
    @(posedge clk);
    #1 {global_output_enable, irq_event, aps_event} = 3'b011;
    go(1, 1, 0, 20'h000ff, 16'h0000);
    chk("disabled ack", lt, 30);
    chk("disabled irq", {irq_request_n_oe_ff, protection_switch_irq_n_oe_ff}, 0);
    @(posedge clk);
    #1 global_output_enable = 1'b1;
    repeat (4) @(posedge clk);
    chk("irq pulled", {irq_request_n_oe_ff, protection_switch_irq_n_oe_ff}, 2'b11);
    #1 {irq_event, aps_event, perf_counter_reset_in} = 3'b001;
    repeat (4) @(posedge clk);
    chk("irq free", {irq_request_n_oe_ff, protection_switch_irq_n_oe_ff}, 0);
    chk("pin clear", {pm_counter_clear_ff, perf_counter_reset_oe_ff}, 2'b10);
    #1 {perf_counter_reset_in, pm_reset_is_output, pm_internal_reset} = 3'b011;
    repeat (4) @(posedge clk);
    chk("internal clear", {pm_counter_clear_ff, perf_counter_reset_oe_ff, perf_counter_reset_out_ff}, 3'b111);
    $display("t_pins done");
endtask
// ----------------------------------------
// main sequence and watchdog
// ----------------------------------------
initial
begin
    {arst_n, global_output_enable, host_port_sync_select} = 3'b011;
    {irq_event, aps_event, pm_reset_is_output, pm_internal_reset, perf_counter_reset_in} = 5'h00;
    repeat (8) @(posedge clk);
    chk("reset drive", {data_oe_ff, transfer_ack_n_oe_ff, irq_request_n_oe_ff, parity_error_ff}, 0);
    #1 arst_n = 1'b1;
    t_sync;
    t_async;
    t_guard;
    t_pins;
    final_report;
end
// about 210 cycles expected; generous margin
initial
begin
    #100us;
    errors++;
    final_report;
end
endmodule
bind crap_host_port crap_host_port_properties #(.ODD_PARITY(ODD_PARITY)) u_crap_host_port_properties (.clk,
    .arst_n, .host_port_sync_select, .chip_select_n, .read_not_write, .global_output_enable, .irq_event,
    .aps_event, .pm_reset_is_output, .data_out_ff, .data_oe_ff, .byte_parity_out_ff, .transfer_ack_n_oe_ff,
    .irq_request_n_oe_ff, .protection_switch_irq_n_oe_ff, .perf_counter_reset_oe_ff, .byte_parity_oe_ff);
